// ### rtl/itwd_top.sv
// Interval timer with supervision timer behind an AHB-Lite register slave.
//
// Behaviour
// - Interval counter is 8-bit, free-running, unstoppable.
// - Counts stable-clock wait after power-on.
// - Counts stable-clock wait after stop exit.
// - Clear bit zeroes counter, self-clears next cycle.
// - Counter value readable, resets to zero.
// - Supervision counter ticks only on overflow.
// - Supervision interval is period times match-plus-one.
// - Mode bit 6 selects timer or reset.
// - Mode bit 5 clears counter, self-clears.
// - Counter equal to match raises flag.
// - Match resets CPU in reset mode.
// - Match written, counter read, same address.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`include "itwd_map.svh"
module itwd_top
  import itwd_pkg::*;
#(
  parameter int unsigned BIT_TICK_CYCLES = `ITWD_BIT_TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic stop_exit,
  output logic clock_stable,
  output logic cpu_reset,
  output logic irq
);

  // Bus phase state.
  logic hreadyout_reg;
  logic hresp_reg;
  logic [31:0] hrdata_reg;
  logic dph_wr_reg;
  itwd_byte_t dph_idx_reg;
  // Interval timer state.
  itwd_byte_t ivl_cnt_reg;
  logic [2:0] ivl_sel_reg;
  logic ivl_clear_reg;
  logic ivl_flag_reg;
  logic clock_stable_reg;
  // Supervision timer state.
  itwd_byte_t sup_cnt_reg;
  itwd_byte_t sup_match_reg;
  logic sup_en_reg;
  logic sup_rsel_reg;
  logic sup_clear_reg;
  logic sup_flag_reg;
  logic cpu_reset_reg;
  // Interrupt block state.
  logic [1:0] irq_status_reg;
  logic [1:0] irq_en_reg;
  logic irq_reg;

  logic ap_valid;
  itwd_byte_t ap_idx;
  itwd_byte_t wdat;
  logic [8:0] sel_span;
  itwd_byte_t sel_mask;
  logic bit_tick;
  logic ovf_evt;
  logic sup_hit;
  logic wr_ctrl;
  logic wr_mode;
  itwd_byte_t rd_mux;

  // Only whole-word transfers are taken; others complete OKAY without effect.
  assign ap_valid = hsel && hready && (htrans == ITWD_TR_NONSEQ || htrans == ITWD_TR_SEQ)
                    && (hsize == 3'h2);
  assign ap_idx = haddr[9:2];
  assign wdat = hwdata[7:0];
  assign wr_ctrl = dph_wr_reg && (dph_idx_reg == `ITWD_IDX_IVL_CTRL);
  assign wr_mode = dph_wr_reg && (dph_idx_reg == `ITWD_IDX_SUP_MODE);

  // The slave never waits and never errors, so both stay at their idle values.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
  end

  // Writes are remembered from the address phase and applied with the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_reg <= 1'b0;
      dph_idx_reg <= 8'h00;
    end else begin
      dph_wr_reg <= ap_valid && hwrite;
      dph_idx_reg <= ap_idx;
    end
  end

  // Read mux; the match value is write-only, so its index reads the counter instead.
  always_comb begin
    rd_mux = 8'h00;
    if (ap_idx == `ITWD_IDX_IVL_CTRL) begin
      rd_mux = {ivl_flag_reg, 3'h0, ivl_clear_reg, ivl_sel_reg};
    end else if (ap_idx == `ITWD_IDX_IVL_COUNT) begin
      rd_mux = ivl_cnt_reg;
    end else if (ap_idx == `ITWD_IDX_SUP_MODE) begin
      rd_mux = {sup_en_reg, sup_rsel_reg, sup_clear_reg, 4'h0, sup_flag_reg};
    end else if (ap_idx == `ITWD_IDX_SUP_MATCH) begin
      rd_mux = sup_cnt_reg;
    end else if (ap_idx == `ITWD_IDX_IRQ_STATUS) begin
      rd_mux = {6'h00, irq_status_reg};
    end else if (ap_idx == `ITWD_IDX_IRQ_ENABLE) begin
      rd_mux = {6'h00, irq_en_reg};
    end
  end

  // Read data is sampled at the address phase and held through the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      hrdata_reg <= {24'h00_0000, rd_mux};
    end
  end

  // Base tick generator; a clear or a stop exit restarts its phase.
  itwd_tick_gen #(
    .DIV(BIT_TICK_CYCLES)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .restart(ivl_clear_reg || stop_exit),
    .tick(bit_tick)
  );

  // Overflow when the low (select+1) bits wrap: 2, 4 .. 256 base ticks.
  assign sel_span = (9'h002 << ivl_sel_reg) - 9'h001;
  assign sel_mask = sel_span[7:0];
  assign ovf_evt = bit_tick && !ivl_clear_reg && ((ivl_cnt_reg & sel_mask) == sel_mask);

  // The counter has no enable; only a clear or a stop exit restarts it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ivl_cnt_reg <= `ITWD_RST_IVL_COUNT;
    end else if (ivl_clear_reg || stop_exit) begin
      ivl_cnt_reg <= 8'h00;
    end else if (bit_tick) begin
      ivl_cnt_reg <= ivl_cnt_reg + 8'h01;
    end
  end

  // Period select and the self-clearing counter clear bit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ivl_sel_reg <= `ITWD_RST_IVL_SEL;
      ivl_clear_reg <= 1'b0;
    end else begin
      ivl_clear_reg <= wr_ctrl && wdat[`ITWD_CTRL_CLEAR_BIT];
      if (wr_ctrl) begin
        ivl_sel_reg <= wdat[`ITWD_CTRL_SEL_MSB:`ITWD_CTRL_SEL_LSB];
      end
    end
  end

  // Overflow flag; a new overflow wins over a simultaneous write of zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ivl_flag_reg <= 1'b0;
    end else if (ovf_evt) begin
      ivl_flag_reg <= 1'b1;
    end else if (wr_ctrl && !wdat[`ITWD_CTRL_FLAG_BIT]) begin
      ivl_flag_reg <= 1'b0;
    end
  end

  // Clock-stable indication: low after reset or stop exit until the first overflow.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_stable_reg <= 1'b0;
    end else if (stop_exit) begin
      clock_stable_reg <= 1'b0;
    end else if (ovf_evt) begin
      clock_stable_reg <= 1'b1;
    end
  end

  // Mode bits and the self-clearing supervision clear bit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sup_en_reg <= 1'b0;
      sup_rsel_reg <= 1'b0;
      sup_clear_reg <= 1'b0;
    end else begin
      sup_clear_reg <= wr_mode && wdat[`ITWD_MODE_CLEAR_BIT];
      if (wr_mode) begin
        sup_en_reg <= wdat[`ITWD_MODE_EN_BIT];
        sup_rsel_reg <= wdat[`ITWD_MODE_RSEL_BIT];
      end
    end
  end

  // Match value; a value of one or less is the software's own lookout.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sup_match_reg <= `ITWD_RST_SUP_MATCH;
    end else if (dph_wr_reg && dph_idx_reg == `ITWD_IDX_SUP_MATCH) begin
      sup_match_reg <= wdat;
    end
  end

  assign sup_hit = ovf_evt && sup_en_reg && !sup_clear_reg
                   && (sup_cnt_reg == sup_match_reg);

  // Counts 0..match on overflows, so a match recurs every match+1 periods.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sup_cnt_reg <= `ITWD_RST_SUP_COUNT;
    end else if (sup_clear_reg || !sup_en_reg) begin
      sup_cnt_reg <= 8'h00;
    end else if (sup_hit) begin
      sup_cnt_reg <= 8'h00;
    end else if (ovf_evt) begin
      sup_cnt_reg <= sup_cnt_reg + 8'h01;
    end
  end

  // Supervision flag with set winning, and the one-cycle CPU reset pulse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sup_flag_reg <= 1'b0;
      cpu_reset_reg <= 1'b0;
    end else begin
      cpu_reset_reg <= sup_hit && sup_rsel_reg;
      if (sup_hit) begin
        sup_flag_reg <= 1'b1;
      end else if (wr_mode && !wdat[`ITWD_MODE_FLAG_BIT]) begin
        sup_flag_reg <= 1'b0;
      end
    end
  end

  // Interrupt block: sticky status, enable mask, write-one-to-clear, set wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_reg <= 2'h0;
      irq_en_reg <= `ITWD_RST_IRQ_ENABLE;
      irq_reg <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `ITWD_IRQ_IVL_BIT) ? ovf_evt : (sup_hit && !sup_rsel_reg)) begin
          irq_status_reg[i] <= 1'b1;
        end else if (dph_wr_reg && dph_idx_reg == `ITWD_IDX_IRQ_CLEAR && wdat[i]) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
      if (dph_wr_reg && dph_idx_reg == `ITWD_IDX_IRQ_ENABLE) begin
        irq_en_reg <= wdat[1:0];
      end
      irq_reg <= |(irq_status_reg & irq_en_reg);
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign clock_stable = clock_stable_reg;
  assign cpu_reset = cpu_reset_reg;
  assign irq = irq_reg;

  // Checks next to the logic they guard.
  a_ivl_clear_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    ivl_clear_reg |=> (ivl_cnt_reg == 8'h00) && !ivl_clear_reg)
    else $error("interval clear did not zero the counter or self-clear");
  a_ivl_free_run: assert property (@(posedge hclk) disable iff (!hresetn)
    (bit_tick && !ivl_clear_reg && !stop_exit) |=> ivl_cnt_reg == $past(ivl_cnt_reg) + 8'h01)
    else $error("interval counter failed to advance on a tick");
  a_ivl_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_evt |=> ivl_flag_reg && irq_status_reg[0])
    else $error("overflow did not set its flags");
  a_ivl_ovf_period: assert property (@(posedge hclk) disable iff (!hresetn)
    (ovf_evt && ivl_sel_reg == 3'h0) |-> ivl_cnt_reg[0])
    else $error("shortest period overflow on an even count");
  a_stable_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_exit |=> !clock_stable_reg && (ivl_cnt_reg == 8'h00))
    else $error("stop exit did not restart the waiting time");
  a_sup_tick_only: assert property (@(posedge hclk) disable iff (!hresetn)
    (!ovf_evt && !sup_clear_reg && sup_en_reg) |=> $stable(sup_cnt_reg))
    else $error("supervision counter moved without an overflow");
  a_sup_match_hit: assert property (@(posedge hclk) disable iff (!hresetn)
    sup_hit |=> sup_flag_reg && (sup_cnt_reg == 8'h00))
    else $error("match did not flag and restart the counter");
  a_sup_reset_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    sup_hit |=> (cpu_reset_reg == $past(sup_rsel_reg)) ##1 !cpu_reset_reg)
    else $error("cpu reset pulse does not follow the mode");
  a_sup_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    sup_clear_reg |=> (sup_cnt_reg == 8'h00) && !sup_clear_reg)
    else $error("supervision clear did not act or self-clear");
  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    |(irq_status_reg & irq_en_reg) |=> irq_reg)
    else $error("enabled status did not raise the interrupt");

  c_overflow: cover property (@(posedge hclk) disable iff (!hresetn) ovf_evt);
  c_match_irq: cover property (@(posedge hclk) disable iff (!hresetn) sup_hit && !sup_rsel_reg);
  c_match_reset: cover property (@(posedge hclk) disable iff (!hresetn) sup_hit && sup_rsel_reg);
  c_stop_exit: cover property (@(posedge hclk) disable iff (!hresetn)
    stop_exit ##1 !clock_stable_reg);

endmodule

// ### rtl/itwd_map.svh
// Register indices, field positions, reset values and timing counts of the interval timer.
`ifndef ITWD_MAP_SVH
`define ITWD_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define ITWD_IDX_IVL_CTRL 8'h8b
`define ITWD_IDX_IVL_COUNT 8'h8c
`define ITWD_IDX_SUP_MODE 8'h8d
`define ITWD_IDX_SUP_MATCH 8'h8e
`define ITWD_IDX_IRQ_STATUS 8'h90
`define ITWD_IDX_IRQ_ENABLE 8'h91
`define ITWD_IDX_IRQ_CLEAR 8'h92

// Interval clock control fields.
`define ITWD_CTRL_FLAG_BIT 7
`define ITWD_CTRL_CLEAR_BIT 3
`define ITWD_CTRL_SEL_MSB 2
`define ITWD_CTRL_SEL_LSB 0

// Supervision mode fields.
`define ITWD_MODE_EN_BIT 7
`define ITWD_MODE_RSEL_BIT 6
`define ITWD_MODE_CLEAR_BIT 5
`define ITWD_MODE_FLAG_BIT 0

// Interrupt status, enable and clear fields.
`define ITWD_IRQ_IVL_BIT 0
`define ITWD_IRQ_SUP_BIT 1

// Reset values.
`define ITWD_RST_IVL_SEL 3'h5
`define ITWD_RST_IVL_COUNT 8'h00
`define ITWD_RST_SUP_MATCH 8'hff
`define ITWD_RST_SUP_COUNT 8'h00
`define ITWD_RST_IRQ_ENABLE 2'h0

// Timing: the interval clock period is 0.256 ms, half of the shortest overflow period.
`define ITWD_CLK_PERIOD_NS 8
`define ITWD_BIT_CLK_PERIOD_NS 256000
`define ITWD_BIT_TICK_CYCLES (`ITWD_BIT_CLK_PERIOD_NS / `ITWD_CLK_PERIOD_NS)

`endif

// ### rtl/itwd_pkg.sv
// Types shared by the interval timer and supervision timer files.
package itwd_pkg;

  typedef logic [7:0] itwd_byte_t;

  // Bus transfer kinds, in the order of their bus encoding.
  typedef enum logic [1:0] {
    ITWD_TR_IDLE,
    ITWD_TR_BUSY,
    ITWD_TR_NONSEQ,
    ITWD_TR_SEQ
  } itwd_htrans_t;

endpackage

// ### rtl/itwd_tick_gen.sv
// Divider that turns the system clock into the interval timer's base tick.
`timescale 1ns/100ps
module itwd_tick_gen #(
  parameter int unsigned DIV = 32000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic restart,
  output logic tick
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] div_cnt_reg;
  logic tick_reg;

  // Restart realigns the phase so a cleared counter sees a full first period.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= '0;
    end else if (restart || div_cnt_reg == LAST) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + CW'(1);
    end
  end

  // One-cycle tick at the end of each base period.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= !restart && (div_cnt_reg == LAST);
    end
  end

  assign tick = tick_reg;

endmodule

// ### sim/itwd_top_tb.sv
// Self-checking testbench for the interval timer with supervision timer.
`timescale 1ns/100ps
`include "itwd_map.svh"
module itwd_top_tb;
  import itwd_pkg::*;
  localparam int unsigned DIV = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = ITWD_TR_IDLE;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic stop_exit = 1'b0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic clock_stable;
  logic cpu_reset;
  logic irq;
  logic irq_d = 1'b0;
  logic [31:0] rd;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed = 64;
  int m;
  int per;
  int irq_q[$];
  int rst_q[$];

  // The only slave drives the bus ready, so the bus ready follows it.
  assign hready = hreadyout;

  itwd_top #(.BIT_TICK_CYCLES(DIV)) itwd_top_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .stop_exit(stop_exit),
    .clock_stable(clock_stable),
    .cpu_reset(cpu_reset),
    .irq(irq)
  );

  // Clock of 8 ns period.
  always #4 hclk = ~hclk;

  // Event model: records the cycle of each interrupt rise and reset pulse, and cuts a hang.
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cpu_reset === 1'b1) rst_q.push_back(cyc);
    if (irq === 1'b1 && irq_d !== 1'b1) irq_q.push_back(cyc);
    irq_d <= irq;
    if (cyc > 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One single-word transfer; the request stands until hready is sampled high.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= ITWD_TR_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= ITWD_TR_IDLE;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(name, rd, exp);
  endtask

  // Waits a bounded number of cycles until a record queue holds n entries.
  task automatic wait_q(input bit use_rst, input int n, input int lim);
    for (int k = 0; k < lim; k++) begin
      if ((use_rst ? rst_q.size() : irq_q.size()) >= n) break;
      @(posedge hclk);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("ctrl_reset", `ITWD_IDX_IVL_CTRL, 32'h05);
    bus(1'b0, `ITWD_IDX_IVL_COUNT, 32'h0);
    chk("count_reset", rd <= 32'h3, 1);
    rchk("mode_reset", `ITWD_IDX_SUP_MODE, 32'h00);
    rchk("supcnt_reset", `ITWD_IDX_SUP_MATCH, 32'h00);
    bus(1'b1, 8'h8f, 32'hff);
    rchk("unmapped", 8'h8f, 32'h00);
    chk("stable_early", clock_stable, 0);
    // Longest period, counter cleared: the flag must not show early but must show in time.
    bus(1'b1, `ITWD_IDX_IVL_CTRL, 32'h0f);
    rchk("clear_self", `ITWD_IDX_IVL_CTRL, 32'h07);
    bus(1'b0, `ITWD_IDX_IVL_COUNT, 32'h0);
    chk("count_clear", rd <= 32'h2, 1);
    repeat (900) @(posedge hclk);
    rchk("flag_early", `ITWD_IDX_IVL_CTRL, 32'h07);
    chk("stable_early2", clock_stable, 0);
    bus(1'b0, `ITWD_IDX_IVL_COUNT, 32'h0);
    chk("count_runs", rd > 32'he0, 1);
    repeat (160) @(posedge hclk);
    rchk("flag_set", `ITWD_IDX_IVL_CTRL, 32'h87);
    chk("stable_pwr", clock_stable, 1);
    bus(1'b1, `ITWD_IDX_IVL_CTRL, 32'h87);
    rchk("flag_w1", `ITWD_IDX_IVL_CTRL, 32'h87);
    bus(1'b1, `ITWD_IDX_IVL_CTRL, 32'h07);
    rchk("flag_w0", `ITWD_IDX_IVL_CTRL, 32'h07);
    // Overflow interrupt: raised when enabled, dropped by the clear register.
    bus(1'b1, `ITWD_IDX_IRQ_ENABLE, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq_ovf", irq, 1);
    bus(1'b1, `ITWD_IDX_IRQ_CLEAR, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq_clr", irq, 0);
    // Shortest period; the supervision interval is period times match plus one.
    bus(1'b1, `ITWD_IDX_IVL_CTRL, 32'h08);
    per = 2 * DIV;
    m = 2 + ($unsigned($random(seed)) % 4);
    bus(1'b1, `ITWD_IDX_SUP_MATCH, m);
    rchk("supcnt_off", `ITWD_IDX_SUP_MATCH, 32'h00);
    bus(1'b1, `ITWD_IDX_IRQ_ENABLE, 32'h2);
    bus(1'b1, `ITWD_IDX_SUP_MODE, 32'ha0);
    irq_q.delete();
    wait_q(1'b0, 1, 400);
    chk("sup_irq1", irq_q.size(), 1);
    bus(1'b1, `ITWD_IDX_IRQ_CLEAR, 32'h2);
    wait_q(1'b0, 2, 400);
    chk("sup_irq2", irq_q.size(), 2);
    chk("sup_gap", irq_q[1] - irq_q[0], (m + 1) * per);
    chk("no_cpu_rst", rst_q.size(), 0);
    rchk("mode_flag", `ITWD_IDX_SUP_MODE, 32'h81);
    rchk("status_sup", `ITWD_IDX_IRQ_STATUS, 32'h3);
    bus(1'b1, `ITWD_IDX_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq_masked", irq, 0);
    // Reset mode: the match pulses the CPU reset and leaves the status bit alone.
    bus(1'b1, `ITWD_IDX_SUP_MODE, 32'he0);
    bus(1'b1, `ITWD_IDX_IRQ_CLEAR, 32'h3);
    rst_q.delete();
    wait_q(1'b1, 2, 600);
    chk("rst_pulses", rst_q.size(), 2);
    chk("rst_gap", rst_q[1] - rst_q[0], (m + 1) * per);
    bus(1'b0, `ITWD_IDX_IRQ_STATUS, 32'h0);
    chk("status_rstm", rd[1], 0);
    bus(1'b0, `ITWD_IDX_SUP_MATCH, 32'h0);
    chk("supcnt_rd", rd <= m, 1);
    // Stop exit drops the stable flag until the next overflow.
    @(posedge hclk);
    stop_exit <= 1'b1;
    @(posedge hclk);
    stop_exit <= 1'b0;
    @(posedge hclk);
    chk("stop_drop", clock_stable, 0);
    repeat (3 * per) @(posedge hclk);
    chk("stop_back", clock_stable, 1);
    close_out();
  end
endmodule
